// ### core/zwst_pkg.sv
/*
  Shared constants and types of the zone wait-state timing block: register
  indexes, field positions, reset values, memory ranges and bus carriers.
  Assumes a 32-bit AXI4-Lite register bus and a 17-bit CPU byte address.
*/
package zwst_pkg;

  // register indexes; the byte address on the bus is four times the index
  localparam int unsigned AXI_AW               = 20;
  localparam logic [17:0] IDX_BUS_UNIT_CONFIG  = 18'h0f900;
  localparam logic [17:0] IDX_IO_ZONE_CONFIG   = 18'h0f902;
  localparam logic [17:0] IDX_ZONE0_CONFIG     = 18'h0f904;
  localparam logic [17:0] IDX_ZONE1_CONFIG     = 18'h0f906;
  localparam logic [17:0] IDX_MODULE_CONFIG    = 18'h0f908;
  localparam logic [17:0] IDX_TIMING_STATUS    = 18'h0f90a;

  // reset values and writable bits (reserved bits are dropped on write)
  localparam logic [7:0]  RST_BUS_UNIT_CONFIG  = 8'h07;
  localparam logic [7:0]  MSK_BUS_UNIT_CONFIG  = 8'h07;
  localparam logic [15:0] RST_ZONE_CONFIG      = 16'h069f;
  localparam logic [15:0] MSK_ZONE_CONFIG      = 16'h0e9f;
  localparam logic [15:0] MSK_IO_CONFIG        = 16'h029f;

  // field positions of the zone, i/o, bus unit and module configuration words
  localparam int unsigned F_WAIT_LO  = 0;
  localparam int unsigned F_HOLD_LO  = 3;
  localparam int unsigned F_BW       = 7;
  localparam int unsigned F_POST_IDLE_ENABLE     = 9;
  localparam int unsigned F_PRE_IDLE_ENABLE     = 10;
  localparam int unsigned F_FRE      = 11;
  localparam int unsigned F_EWR      = 0;
  localparam int unsigned F_EEPROM_ZERO_WAIT   = 0;

  // cycle counts of the basic bus cycles
  localparam logic [4:0] CYC_SINGLE  = 5'h01;
  localparam logic [4:0] CYC_NORMAL  = 5'h02;
  localparam logic [4:0] CYC_IO_BASE = 5'h03;

  // memory map of the cpu side, inclusive bounds
  localparam logic [16:0] FLASH_LO_A = 17'h00000;
  localparam logic [16:0] FLASH_HI_A = 17'h0bfff;
  localparam logic [16:0] FLASH_LO_B = 17'h1c000;
  localparam logic [16:0] FLASH_HI_B = 17'h1ffff;
  localparam logic [16:0] RAM_LO     = 17'h0c000;
  localparam logic [16:0] RAM_HI     = 17'h0cbff;
  localparam logic [16:0] BOOT_LO    = 17'h0e000;
  localparam logic [16:0] BOOT_HI    = 17'h0e5ff;
  localparam logic [16:0] EE_LO      = 17'h0f000;
  localparam logic [16:0] EE_HI      = 17'h0f27f;
  localparam logic [16:0] PER_LO_A   = 17'h0f800;
  localparam logic [16:0] PER_HI_A   = 17'h0faff;
  localparam logic [16:0] PER_LO_B   = 17'h0fc00;
  localparam logic [16:0] PER_HI_B   = 17'h0ffff;
  localparam logic [16:0] IO_LO      = 17'h0fb00;
  localparam logic [16:0] IO_HI      = 17'h0fb16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RG_NONE = 3'h0, RG_ZONE0 = 3'h1, RG_ZONE1 = 3'h2, RG_RAM = 3'h3,
    RG_EE   = 3'h4, RG_PERIPH = 3'h5, RG_IO = 3'h6
  } zwst_region_t;

  typedef enum logic [1:0] {
    PH_READY = 2'b00, PH_IDLE = 2'b01, PH_ACCESS = 2'b11
  } zwst_phase_t;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } zwst_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } zwst_axi_rsp_t;

endpackage : zwst_pkg

// ### core/zwst_timing.sv
/*
  Zone wait-state timing: register file on AXI4-Lite and the sequencer that
  stretches every cpu bus access by its zone's idle cycles and, outside fast mode, its wait and hold cycles.
  Assumes one 100 MHz clock shared with the cpu core and the register bus.
*/
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

module zwst_timing
  import zwst_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire zwst_axi_req_t axiReq,
  output zwst_axi_rsp_t      axiRsp,
  input  wire logic          cpuReq,
  input  wire logic [16:0]   cpuAddr,
  input  wire logic          cpuWrite,
  output logic               cpuReady,
  output logic               cpuDone,
  output logic               busIdle,
  output logic               busWide16,
  output zwst_region_t       activeZone
);

  typedef struct packed {
    logic [7:0]        busCfg;
    logic [15:0]       io_zone_timing_config;
    logic [15:0]       z0Cfg;
    logic [15:0]       z1Cfg;
    logic              eeZeroWait;
    zwst_phase_t       phase;
    logic [1:0]        idleCnt;
    logic [4:0]        accCnt;
    zwst_region_t      lastZone;
    zwst_region_t      curZone;
    logic              wide;
    logic              awHeld;
    logic [AXI_AW-1:0] awAddr;
    logic              wHeld;
    logic [15:0]       wData;
    logic [1:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [15:0]       rData;
    logic [1:0]        rResp;
  } zwst_state_t;

  zwst_state_t st_q;
  zwst_state_t st_d;

  // address decode of the cpu side, also used by the checks below
  function automatic zwst_region_t regionOf(input logic [16:0] a);
    zwst_region_t r;
    r = RG_NONE;
    if ((a >= FLASH_LO_A && a <= FLASH_HI_A) || (a >= FLASH_LO_B && a <= FLASH_HI_B))
      r = RG_ZONE0;
    else if (a >= RAM_LO && a <= RAM_HI)
      r = RG_RAM;
    else if (a >= BOOT_LO && a <= BOOT_HI)
      r = RG_ZONE1;
    else if (a >= EE_LO && a <= EE_HI)
      r = RG_EE;
    else if (a >= IO_LO && a <= IO_HI)
      r = RG_IO;
    else if ((a >= PER_LO_A && a <= PER_HI_A) || (a >= PER_LO_B && a <= PER_HI_B))
      r = RG_PERIPH;
    return r;
  endfunction : regionOf

  // configuration word that governs a region, zero where none does
  function automatic logic [15:0] cfgOf(input zwst_region_t r, input zwst_state_t s);
    logic [15:0] c;
    c = '0;
    if (r == RG_ZONE0)
      c = s.z0Cfg;
    else if (r == RG_ZONE1)
      c = s.z1Cfg;
    else if (r == RG_IO)
      c = s.io_zone_timing_config;
    return c;
  endfunction : cfgOf

  // total access cycles of one bus cycle, idle cycles excluded
  function automatic logic [4:0] accessCycles(input zwst_region_t r, input logic wr,
                                              input zwst_state_t s);
    logic [15:0] c;
    logic [4:0]  wt;
    logic [4:0]  hd;
    logic [4:0]  ew;
    logic [4:0]  n;
    c  = cfgOf(r, s);
    wt = {2'h0, c[F_WAIT_LO +: 3]};
    hd = {3'h0, c[F_HOLD_LO +: 2]};
    ew = {4'h0, s.busCfg[F_EWR]};
    n  = CYC_SINGLE;
    unique case (r)
      RG_ZONE0, RG_ZONE1:
        if (c[F_FRE])
          n = wr ? CYC_NORMAL : CYC_SINGLE;
        else if (wr)
          n = CYC_NORMAL + ew + wt + hd;
        else
          n = CYC_NORMAL + wt + hd;
      RG_RAM:    n = CYC_SINGLE;
      RG_EE:     n = s.eeZeroWait ? CYC_SINGLE : CYC_NORMAL;
      RG_PERIPH: n = CYC_NORMAL;
      RG_IO:     n = CYC_IO_BASE + wt + hd + (wr ? ew : 5'h00);
      default:   n = CYC_SINGLE;
    endcase
    return n;
  endfunction : accessCycles

  // idle cycles owed when the access leaves one zone for another
  function automatic logic [1:0] idleCycles(input zwst_region_t r, input zwst_state_t s);
    logic [15:0] cOld;
    logic [15:0] cNew;
    logic [1:0]  n;
    cOld = cfgOf(s.lastZone, s);
    cNew = cfgOf(r, s);
    n    = 2'h0;
    if (r != s.lastZone)
    begin
      n = {1'b0, cOld[F_POST_IDLE_ENABLE]};
      if (r != RG_IO)
        n = n + {1'b0, cNew[F_PRE_IDLE_ENABLE]};
    end
    return n;
  endfunction : idleCycles

  // byte-lane merge of a 16-bit register, reserved bits forced low
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat,
                                        input logic [1:0] strb, input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (strb[0])
      v[7:0] = dat[7:0];
    if (strb[1])
      v[15:8] = dat[15:8];
    return v & msk;
  endfunction : merge

  logic         accept;
  zwst_region_t reqZone;
  logic         wrFire;
  logic         wrHit;
  logic         rdHit;
  logic [17:0]  wrIdx;
  logic [17:0]  rdIdx;

  assign accept  = cpuReq && cpuReady;
  assign reqZone = regionOf(cpuAddr);
  assign wrFire  = st_q.awHeld && st_q.wHeld && !st_q.bValid;
  assign wrIdx   = st_q.awAddr[AXI_AW-1:2];
  assign rdIdx   = axiReq.araddr[AXI_AW-1:2];
  assign wrHit   = wrIdx inside {IDX_BUS_UNIT_CONFIG, IDX_IO_ZONE_CONFIG, IDX_ZONE0_CONFIG,
                                 IDX_ZONE1_CONFIG, IDX_MODULE_CONFIG};
  assign rdHit   = rdIdx inside {IDX_BUS_UNIT_CONFIG, IDX_IO_ZONE_CONFIG, IDX_ZONE0_CONFIG,
                                 IDX_ZONE1_CONFIG, IDX_MODULE_CONFIG, IDX_TIMING_STATUS};

  // next state: register bus slave and access sequencer in one pass
  always_comb
  begin
    logic [15:0] rd;
    logic        hit;
    st_d = st_q;
    rd   = '0;
    hit  = 1'b1;
    // write channel: address and data taken in either order, answer after both
    if (axiReq.awvalid && !st_q.awHeld && !st_q.bValid)
    begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !st_q.wHeld && !st_q.bValid)
    begin
      st_d.wHeld = 1'b1;
      st_d.wData = axiReq.wdata[15:0];
      st_d.wStrb = axiReq.wstrb[1:0];
    end
    if (wrFire)
    begin
      unique case (wrIdx)
        IDX_BUS_UNIT_CONFIG:
          if (st_q.wStrb[0])
            st_d.busCfg = st_q.wData[7:0] & MSK_BUS_UNIT_CONFIG;
        IDX_IO_ZONE_CONFIG:
          st_d.io_zone_timing_config = merge(st_q.io_zone_timing_config, st_q.wData, st_q.wStrb, MSK_IO_CONFIG);
        IDX_ZONE0_CONFIG:
          st_d.z0Cfg = merge(st_q.z0Cfg, st_q.wData, st_q.wStrb, MSK_ZONE_CONFIG);
        IDX_ZONE1_CONFIG:
          st_d.z1Cfg = merge(st_q.z1Cfg, st_q.wData, st_q.wStrb, MSK_ZONE_CONFIG);
        IDX_MODULE_CONFIG:
          if (st_q.wStrb[0])
            st_d.eeZeroWait = st_q.wData[F_EEPROM_ZERO_WAIT];
        default: ;
      endcase
      st_d.awHeld = 1'b0;
      st_d.wHeld  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_q.bValid && axiReq.bready)
      st_d.bValid = 1'b0;
    // read channel: one read at a time, answered on the cycle after the address
    unique case (rdIdx)
      IDX_BUS_UNIT_CONFIG: rd = {8'h00, st_q.busCfg};
      IDX_IO_ZONE_CONFIG:  rd = st_q.io_zone_timing_config;
      IDX_ZONE0_CONFIG:    rd = st_q.z0Cfg;
      IDX_ZONE1_CONFIG:    rd = st_q.z1Cfg;
      IDX_MODULE_CONFIG:   rd = {15'h0000, st_q.eeZeroWait};
      IDX_TIMING_STATUS:   rd = {8'h00, st_q.curZone, st_q.lastZone, st_q.phase};
      default:             hit = 1'b0;
    endcase
    if (axiReq.arvalid && !st_q.rValid)
    begin
      st_d.rValid = 1'b1;
      st_d.rData  = rd;
      st_d.rResp  = (hit && rdHit) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_q.rValid && axiReq.rready)
      st_d.rValid = 1'b0;
    // access sequencer: idle cycles first, then the counted access cycles
    unique case (st_q.phase)
      PH_READY:
        if (accept)
        begin
          st_d.accCnt   = accessCycles(reqZone, cpuWrite, st_q);
          st_d.idleCnt  = idleCycles(reqZone, st_q);
          st_d.phase    = (idleCycles(reqZone, st_q) != 2'h0) ? PH_IDLE : PH_ACCESS;
          st_d.curZone  = reqZone;
          st_d.lastZone = reqZone;
          st_d.wide     = (cfgOf(reqZone, st_q) & (16'h0001 << F_BW)) != 16'h0000;
        end
      PH_IDLE:
      begin
        st_d.idleCnt = st_q.idleCnt - 2'h1;
        if (st_q.idleCnt == 2'h1)
          st_d.phase = PH_ACCESS;
      end
      PH_ACCESS:
      begin
        st_d.accCnt = st_q.accCnt - 5'h01;
        if (st_q.accCnt == CYC_SINGLE)
          st_d.phase = PH_READY;
      end
      default: st_d.phase = PH_READY;
    endcase
  end

  // state register; the zone registers come up in the slow default timing
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_q            <= '0;
      st_q.busCfg     <= RST_BUS_UNIT_CONFIG;
      st_q.io_zone_timing_config      <= RST_ZONE_CONFIG;
      st_q.z0Cfg      <= RST_ZONE_CONFIG;
      st_q.z1Cfg      <= RST_ZONE_CONFIG;
      st_q.phase      <= PH_READY;
      st_q.lastZone   <= RG_NONE;
      st_q.curZone    <= RG_NONE;
    end
    else
      st_q <= st_d;
  end

  // outputs: cpu handshakes decoded from the phase and count, register bus valids, responses and data straight from flops, readies decoded from them
  assign cpuReady       = st_q.phase == PH_READY;
  assign cpuDone        = st_q.phase == PH_ACCESS && st_q.accCnt == CYC_SINGLE;
  assign busIdle        = st_q.phase == PH_IDLE;
  assign busWide16      = st_q.wide;
  assign activeZone     = st_q.curZone;
  assign axiRsp.awready = !st_q.awHeld && !st_q.bValid;
  assign axiRsp.wready  = !st_q.wHeld && !st_q.bValid;
  assign axiRsp.bvalid  = st_q.bValid;
  assign axiRsp.bresp   = st_q.bResp;
  assign axiRsp.arready = !st_q.rValid;
  assign axiRsp.rvalid  = st_q.rValid;
  assign axiRsp.rdata   = {16'h0000, st_q.rData};
  assign axiRsp.rresp   = st_q.rResp;

  // checks: all but the idle and reset checks tie the done pulse to the access that caused it
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic        sameZone;
  logic [15:0] z0;
  assign sameZone = reqZone == st_q.lastZone;
  assign z0       = st_q.z0Cfg;

  a_ram_single: assert property (
    accept && reqZone == RG_RAM && sameZone |=> cpuDone)
    else $error("ram access did not finish in one cycle");

  a_fast_read_one: assert property (
    accept && reqZone == RG_ZONE0 && !cpuWrite && z0[F_FRE] && sameZone |=> cpuDone)
    else $error("fast zone 0 read took more than one cycle");

  a_normal_read_two: assert property (
    accept && reqZone == RG_ZONE0 && !cpuWrite && !z0[F_FRE] |=> !cpuDone)
    else $error("normal zone 0 read finished in one cycle");

  a_wait_field_max: assert property (
    accept && reqZone == RG_ZONE0 && !cpuWrite && sameZone && z0[11:0] == 12'h087
    |=> !cpuDone [*8] ##1 cpuDone)
    else $error("zone 0 read with seven waits not nine cycles");

  a_hold_field_max: assert property (
    accept && reqZone == RG_ZONE0 && !cpuWrite && sameZone && z0[11:0] == 12'h098
    |=> !cpuDone [*4] ##1 cpuDone)
    else $error("zone 0 read with three holds not five cycles");

  a_fast_write_wait: assert property (
    accept && reqZone == RG_ZONE0 && cpuWrite && z0[F_FRE] && sameZone
    |=> !cpuDone ##1 cpuDone)
    else $error("fast mode zone 0 write not two cycles");

  a_early_write_len: assert property (
    accept && reqZone == RG_ZONE0 && cpuWrite && sameZone && z0[11:0] == 12'h080
    && st_q.busCfg[F_EWR] |=> !cpuDone [*2] ##1 cpuDone)
    else $error("early write to zone 0 not three cycles");

  a_eeprom_wait: assert property (
    accept && reqZone == RG_EE && sameZone && !st_q.eeZeroWait |=> !cpuDone ##1 cpuDone)
    else $error("eeprom access without zero wait not two cycles");

  a_periph_two: assert property (
    accept && reqZone == RG_PERIPH && sameZone |=> !cpuDone ##1 cpuDone)
    else $error("peripheral access not two cycles");

  a_pre_idle_ins: assert property (
    accept && reqZone == RG_ZONE0 && st_q.lastZone == RG_RAM && z0[F_PRE_IDLE_ENABLE] |=> busIdle)
    else $error("no idle cycle before entering zone 0");

  a_zone0_reset: assert property (
    $fell(sys_rst) |-> st_q.z0Cfg == RST_ZONE_CONFIG && st_q.z1Cfg == RST_ZONE_CONFIG)
    else $error("zone registers left reset with wrong value");

  c_zone_switch:  cover property (accept && !sameZone ##1 busIdle [*2] ##1 !busIdle);
  c_io_write:     cover property (accept && reqZone == RG_IO && cpuWrite);
  c_axi_write:    cover property (wrFire && wrIdx == IDX_ZONE0_CONFIG);
  c_fast_read:    cover property (accept && reqZone == RG_ZONE0 && z0[F_FRE] ##1 cpuDone);

endmodule : zwst_timing

// ### bench/zwst_cpu_model.sv
/*
  Cpu core model: issues one memory request at a time and holds it.
  Assumes the block's cpuReady handshake and one shared clock.
*/
`timescale 1ns/1ps
module zwst_cpu_model
  import zwst_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        startReq,
  input  wire logic [16:0] reqAddr,
  input  wire logic        reqWrite,
  input  wire logic        cpuReady,
  output logic             cpuReq,
  output logic [16:0]      cpuAddr,
  output logic             cpuWrite
);
  // request stands until the edge that samples ready high; a released
  // address shows its inverse so a stale value never looks valid
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cpuReq   <= 1'b0;
      cpuAddr  <= 17'h00000;
      cpuWrite <= 1'b0;
    end
    else if (cpuReq && cpuReady)
    begin
      cpuReq   <= 1'b0;
      cpuAddr  <= ~cpuAddr;
      cpuWrite <= ~cpuWrite;
    end
    else if (!cpuReq && startReq)
    begin
      cpuReq   <= 1'b1;
      cpuAddr  <= reqAddr;
      cpuWrite <= reqWrite;
    end
  end
endmodule : zwst_cpu_model

// ### bench/test_zone_wait_state_timing.sv
/*
  Self-checking bench of the zone wait-state timing block.
  Assumes the cpu model beside it and an AXI4-Lite master in this module.
*/
`timescale 1ns/1ps
module test_zone_wait_state_timing
  import zwst_pkg::*;
;
  typedef struct {logic [31:0] data; logic [1:0] resp;} zwst_axn_t;
  typedef struct {int lat; int idl; zwst_region_t rg;} zwst_cpn_t;

  logic          clock;
  logic          sys_rst;
  zwst_axi_req_t axiReq;
  zwst_axi_rsp_t axiRsp;
  logic          cpuReq;
  logic [16:0]   cpuAddr;
  logic          cpuWrite;
  logic          cpuReady;
  logic          cpuDone;
  logic          busIdle;
  logic          busWide16;
  zwst_region_t  activeZone;
  logic          stReq;
  logic [16:0]   stAddr;
  logic          stWr;
  int            errCount;
  int            nTests;
  int            seed;
  int            cyc;
  int            t0;
  int            idl;
  logic          zPend;
  zwst_cpn_t     ce;
  zwst_axn_t     an;
  zwst_axn_t     axQ[$];
  zwst_cpn_t     cpuQ[$];
  logic [15:0]   z0, z1, io;
  logic [7:0]    buc, mc;
  zwst_region_t  lastRg;

  zwst_timing dut_u (.clock(clock), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuReady(cpuReady),
    .cpuDone(cpuDone), .busIdle(busIdle), .busWide16(busWide16), .activeZone(activeZone));

  zwst_cpu_model cpu_u (.clock(clock), .sys_rst(sys_rst), .startReq(stReq),
    .reqAddr(stAddr), .reqWrite(stWr), .cpuReady(cpuReady), .cpuReq(cpuReq),
    .cpuAddr(cpuAddr), .cpuWrite(cpuWrite));

  // free-running 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic conclude();
    if (errCount == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic hang();
    errCount++;
    conclude();
  endtask : hang

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      errCount++;
    end
  endtask : check

  function automatic logic [15:0] cfgOf(zwst_region_t rg);
    return (rg == RG_ZONE1) ? z1 : (rg == RG_IO) ? io : z0;
  endfunction : cfgOf

  // expected access and idle cycles, worked out from the shadow registers
  function automatic zwst_cpn_t expOf(zwst_region_t rg, logic wr);
    logic [15:0] c;
    logic [15:0] p;
    zwst_cpn_t   e;
    c = cfgOf(rg);
    p = cfgOf(lastRg);
    case (rg)
      RG_ZONE0, RG_ZONE1: e.lat = c[F_FRE] ? (wr ? 2 : 1)
                                : 2 + c[2:0] + c[4:3] + (wr ? buc[F_EWR] : 0);
      RG_EE:     e.lat = mc[F_EEPROM_ZERO_WAIT] ? 1 : 2;
      RG_PERIPH: e.lat = 2;
      RG_IO:     e.lat = 3 + c[2:0] + c[4:3] + (wr ? buc[F_EWR] : 0);
      default:   e.lat = 1;
    endcase
    e.idl = 0;
    if (rg != lastRg && lastRg inside {RG_ZONE0, RG_ZONE1, RG_IO})
      e.idl += p[F_POST_IDLE_ENABLE];
    if (rg != lastRg && rg inside {RG_ZONE0, RG_ZONE1})
      e.idl += c[F_PRE_IDLE_ENABLE];
    e.rg = rg;
    return e;
  endfunction : expOf

  function automatic logic [16:0] addrOf(zwst_region_t rg, logic alt);
    case (rg)
      RG_ZONE0:  return alt ? FLASH_LO_B : FLASH_HI_A;
      RG_ZONE1:  return alt ? BOOT_HI : BOOT_LO;
      RG_RAM:    return alt ? RAM_HI : RAM_LO;
      RG_EE:     return alt ? EE_HI : EE_LO;
      RG_PERIPH: return alt ? PER_LO_B : PER_HI_A;
      RG_IO:     return alt ? IO_HI : IO_LO;
      default:   return alt ? 17'h0f300 : 17'h0d000;
    endcase
  endfunction : addrOf

  task automatic axiWrite(input logic [17:0] idx, input logic [15:0] d, input logic [1:0] rsp);
    int n;
    axQ.push_back('{32'h0, rsp});
    axiReq.awaddr  <= {idx, 2'b00};
    axiReq.awvalid <= 1'b1;
    axiReq.wdata   <= {16'h0000, d};
    axiReq.wstrb   <= 4'h3;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      n++;
    end
    while (axiRsp.bvalid !== 1'b1 && n < 100);
    axiReq.bready <= 1'b0;
    // one edge passes so a following call never re-raises bready in this step
    @(posedge clock);
    if (n >= 100) hang();
  endtask : axiWrite

  task automatic axiRead(input logic [17:0] idx, input logic [15:0] d, input logic [1:0] rsp);
    int n;
    axQ.push_back('{{16'h0000, d}, rsp});
    axiReq.araddr  <= {idx, 2'b00};
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      n++;
    end
    while (axiRsp.rvalid !== 1'b1 && n < 100);
    axiReq.rready <= 1'b0;
    // one edge passes so a following call never re-raises rready in this step
    @(posedge clock);
    if (n >= 100) hang();
  endtask : axiRead

  // hands one request to the cpu model and returns once it is taken
  task automatic cpuAccess(input zwst_region_t rg, input logic wr, input logic alt);
    int n;
    cpuQ.push_back(expOf(rg, wr));
    lastRg = rg;
    stReq  <= 1'b1;
    stAddr <= addrOf(rg, alt);
    stWr   <= wr;
    @(posedge clock);
    stReq <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (cpuReq === 1'b1 && n < 100);
    if (n >= 100) hang();
  endtask : cpuAccess

  task automatic drain();
    int n;
    for (n = 0; n < 100 && cpuQ.size() > 0; n++)
      @(posedge clock);
    if (cpuQ.size() > 0) hang();
  endtask : drain

  // one zone 0 setting, entered from ram and then repeated within zone 0
  task automatic zoneRun(input logic [15:0] z, input logic wr);
    drain();
    z0 = z;
    axiWrite(IDX_ZONE0_CONFIG, z0, RESP_OKAY);
    cpuAccess(RG_RAM, wr, 1'b0);
    cpuAccess(RG_ZONE0, wr, 1'b0);
    cpuAccess(RG_ZONE0, wr, 1'b1);
  endtask : zoneRun

  // register bus answers, compared against the oldest note
  always @(posedge clock)
  begin
    if (axiRsp.bvalid && axiReq.bready)
    begin
      an = axQ.pop_front();
      check("bresp", {30'h0, axiRsp.bresp}, {30'h0, an.resp});
    end
    if (axiRsp.rvalid && axiReq.rready)
    begin
      an = axQ.pop_front();
      check("rresp", {30'h0, axiRsp.rresp}, {30'h0, an.resp});
      if (an.resp == RESP_OKAY) check("rdata", axiRsp.rdata, an.data);
    end
  end

  // cpu side: latency from the taking edge to done, idle cycles between
  always @(posedge clock)
  begin
    cyc++;
    if (zPend)
    begin
      check("zone", {29'h0, activeZone}, {29'h0, ce.rg});
      if (ce.rg inside {RG_ZONE0, RG_ZONE1}) check("width", {31'h0, busWide16}, 32'h1);
      zPend = 1'b0;
    end
    if (!sys_rst && cpuDone === 1'b1)
    begin
      ce = cpuQ.pop_front();
      check("latency", cyc - t0, ce.lat + ce.idl);
      check("idle", idl, ce.idl);
      zPend = 1'b1;
    end
    if (cpuReq && cpuReady === 1'b1)
    begin
      t0  = cyc;
      idl = 0;
    end
    else if (busIdle === 1'b1)
      idl++;
  end

  // main sequence: reset values, every region at reset timing, then random timing
  initial
  begin
    logic [31:0] r;
    int          it;
    int          k;
    errCount = 0;
    nTests   = 0;
    cyc      = 0;
    t0       = 0;
    idl      = 0;
    zPend    = 1'b0;
    seed     = 32'h4b9a7186;
    axiReq   = '0;
    stReq    = 1'b0;
    stAddr   = 17'h00000;
    stWr     = 1'b0;
    sys_rst  = 1'b1;
    z0 = 16'h069f;
    z1 = 16'h069f;
    io = 16'h069f;
    buc = 8'h07;
    mc = 8'h00;
    lastRg = RG_NONE;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    axiRead(IDX_BUS_UNIT_CONFIG, 16'h0007, RESP_OKAY);
    axiRead(IDX_IO_ZONE_CONFIG, 16'h069f, RESP_OKAY);
    axiRead(IDX_ZONE0_CONFIG, 16'h069f, RESP_OKAY);
    axiRead(IDX_ZONE1_CONFIG, 16'h069f, RESP_OKAY);
    axiRead(18'h0f90c, 16'h0000, RESP_SLVERR);
    axiWrite(18'h0f90c, 16'h0000, RESP_SLVERR);
    for (k = 0; k < 14; k++)
      cpuAccess(zwst_region_t'(k % 7), k[0], k[1]);
    for (it = 0; it < 12; it++)
    begin
      drain();
      r = $random(seed);
      z0 = (r[15:0] & MSK_ZONE_CONFIG) | 16'h0080;
      z1 = (r[31:16] & MSK_ZONE_CONFIG) | 16'h0080;
      r = $random(seed);
      io = (r[15:0] & MSK_IO_CONFIG) | 16'h0080;
      buc = {5'h00, 2'b11, r[16]};
      mc = {7'h00, r[17]};
      axiWrite(IDX_ZONE0_CONFIG, z0, RESP_OKAY);
      axiWrite(IDX_ZONE1_CONFIG, z1, RESP_OKAY);
      axiWrite(IDX_IO_ZONE_CONFIG, io, RESP_OKAY);
      axiWrite(IDX_BUS_UNIT_CONFIG, {8'h00, buc}, RESP_OKAY);
      axiWrite(IDX_MODULE_CONFIG, {8'h00, mc}, RESP_OKAY);
      axiRead(IDX_ZONE1_CONFIG, z1, RESP_OKAY);
      axiRead(IDX_BUS_UNIT_CONFIG, {8'h00, buc}, RESP_OKAY);
      for (k = 0; k < 8; k++)
      begin
        r = $random(seed);
        cpuAccess(zwst_region_t'(3'(r[7:0] % 7)), r[8], r[9]);
      end
    end
    // directed runs: every fixed timing case of the checks meets its trigger
    buc = 8'h07;
    mc  = 8'h00;
    drain();
    axiWrite(IDX_BUS_UNIT_CONFIG, {8'h00, buc}, RESP_OKAY);
    axiWrite(IDX_MODULE_CONFIG, {8'h00, mc}, RESP_OKAY);
    zoneRun(16'h0087, 1'b0);
    zoneRun(16'h0098, 1'b0);
    zoneRun(16'h0080, 1'b1);
    zoneRun(16'h0c80, 1'b0);
    zoneRun(16'h0c80, 1'b1);
    for (k = 0; k < 6; k++)
      cpuAccess(zwst_region_t'(3 + k / 2), 1'b0, k[0]);
    drain();
    repeat (2) @(posedge clock);
    axiRead(IDX_TIMING_STATUS, {8'h00, lastRg, lastRg, 2'b00}, RESP_OKAY);
    conclude();
  end
endmodule : test_zone_wait_state_timing
